// ---- shared/flash_host_cfg.svh ----
/*
 * timing counts, register offsets and field positions for the flash host.
 * assumes a 250 MHz core clock; included by its bare name.
 */
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

`define CLK_MHZ            250
// bus pulse lengths in ns, cycles derived with round up
`define CWC_NS             120
`define WE_LOW_NS          50
`define CWC_CYC            ((`CWC_NS * `CLK_MHZ + 999) / 1000)
`define WE_LOW_CYC         ((`WE_LOW_NS * `CLK_MHZ + 999) / 1000)
`define OE_READ_NS         120
`define OE_READ_CYC        ((`OE_READ_NS * `CLK_MHZ + 999) / 1000)
// protect pulse timings
`define PROT_WE_US         10
`define UNPROT_WE_MS       12
`define OE_SETUP_US        4
`define PROT_WE_CYC        (`PROT_WE_US * `CLK_MHZ)
`define UNPROT_WE_CYC      (`UNPROT_WE_MS * 1000 * `CLK_MHZ)
`define OE_SETUP_CYC       (`OE_SETUP_US * `CLK_MHZ)
// watchdog limits
`define SECT_ERASE_MAX_S   8
`define CHIP_ERASE_MAX_S   24
`define BYTE_PROG_MAX_US   210
`define WORD_PROG_MAX_US   360
`define SECT_ERASE_CYC     (`SECT_ERASE_MAX_S * 1000000 * `CLK_MHZ)
`define CHIP_ERASE_CYC     (`CHIP_ERASE_MAX_S * 36'd1000000 * `CLK_MHZ)
`define BYTE_PROG_CYC      (`BYTE_PROG_MAX_US * `CLK_MHZ)
`define WORD_PROG_CYC      (`WORD_PROG_MAX_US * `CLK_MHZ)

// command cycles
`define UNLOCK_ADDR1       16'h0555
`define UNLOCK_ADDR2       16'h02AA
`define UNLOCK_DATA1       16'h00AA
`define UNLOCK_DATA2       16'h0055
`define PROG_CMD           16'h00A0
`define ERASE_CMD          16'h0080
`define CHIP_ERASE_CMD     16'h0010
`define SECT_ERASE_CMD     16'h0030
`define RESET_CMD          16'h00F0

// status bit positions on the data lines; sector field bit positions on the address lines
`define POLL_BIT           7
`define TOGGLE_BIT         6
`define LIMIT_BIT          5
`define ETIMEOUT_BIT       3
`define SECT_LO_BIT        12
`define SECT_HI_BIT        15

// register offsets
`define REG_CTRL           8'h00
`define REG_ADDR           8'h04
`define REG_DATA           8'h08
`define REG_STATUS         8'h0C
`define REG_IRQ_STAT       8'h10
`define REG_IRQ_EN         8'h14
`define REG_IRQ_CLR        8'h18
`define REG_PULSE          8'h1C

`endif

// ---- shared/flash_host_pkg.sv ----
/*
 * types shared by the flash host controller.
 * assumes nothing beyond the cfg header.
 */
package flash_host_pkg;
	typedef enum logic [2:0] {
		OP_NONE, OP_PROG, OP_CHIP_ERASE, OP_SECT_ERASE,
		OP_RESET, OP_PROTECT, OP_UNPROTECT
	} op_t;

	typedef struct packed {
		logic [16:0] addr;
		logic [15:0] dout;
		logic        dout_oe_n;
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
	} flash_pins_t;
endpackage

// ---- rtl/flash_host.sv ----
/*
 * host controller for a parallel flash with embedded program and erase.
 * assumes an AHB-Lite master on the register side and the flash pins
 * driven straight from here; data inputs come from pins and are synced.
 */
// Our own choices: the AHB-Lite register port and the register offsets.
// Functional notes
// - program starts with AA@555, 55@2AA, A0@555, then address and data.
// - bit 6 toggles on successive reads while busy; host polls it.
// - toggling with bit 5 high means failure; host sends reset command.
// - protect pulse holds write strobe low at least 10 us.
// - unprotect pulse holds write strobe low at least 12 ms.
// - output strobe asserted at least 4 us before write strobe.
`timescale 1ns/10ps
`include "flash_host_cfg.svh"

module flash_host
	import flash_host_pkg::*;
#(
	parameter int unsigned SECT_ERASE_CYC = `SECT_ERASE_CYC,
	parameter logic [35:0] CHIP_ERASE_CYC = `CHIP_ERASE_CYC,
	parameter int unsigned UNPROT_WE_CYC  = `UNPROT_WE_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output flash_pins_t      pins,
	input  wire logic [15:0] flash_din,
	output logic             irq
);
	typedef enum {
		S_IDLE, S_CMD_SETUP, S_CMD_LOW, S_CMD_HIGH, S_POLL_LOW,
		S_POLL_EVAL, S_PROT_OE, S_PROT_WE, S_PROT_END
	} state_t;

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	logic [7:0]  a_off;
	logic        a_wr;
	logic        a_vld;
	logic [2:0]  ctrl_op;
	logic        ctrl_word;
	logic [16:0] op_addr;
	logic [15:0] op_data;
	logic [3:0]  irq_stat;
	logic [3:0]  irq_en;
	logic        busy;
	logic        fail;
	logic        start;
	logic [3:0]  ev;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			a_vld <= 1'b0;
			a_wr  <= 1'b0;
			a_off <= 8'h00;
		end else if (hready) begin
			a_vld <= hsel & htrans[1];
			a_wr  <= hwrite;
			a_off <= haddr[7:0];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_op   <= 3'h0;
			ctrl_word <= 1'b0;
			op_addr   <= 17'h00000;
			op_data   <= 16'h0000;
			irq_en    <= 4'h0;
			start     <= 1'b0;
			irq_stat  <= 4'h0;
		end else begin
			start <= 1'b0;
			// set wins over a clear in the same cycle
			irq_stat <= ev | (irq_stat &
				~((a_vld && a_wr && a_off == `REG_IRQ_CLR) ?
				hwdata[3:0] : 4'h0));
			if (a_vld && a_wr) begin
				case (a_off)
				// a command write while an operation runs is dropped
				`REG_CTRL: if (!busy && !start) begin
					ctrl_op   <= hwdata[2:0];
					ctrl_word <= hwdata[4];
					start     <= 1'b1;
				end
				`REG_ADDR:   op_addr <= hwdata[16:0];
				`REG_DATA:   op_data <= hwdata[15:0];
				`REG_IRQ_EN: irq_en  <= hwdata[3:0];
				default: ;
				endcase
			end
		end
	end

	logic [31:0] rd_mux;
	logic [15:0] last_read;
	always_comb begin
		case (a_off)
		`REG_CTRL:     rd_mux = {27'h0, ctrl_word, 1'b0, ctrl_op};
		`REG_ADDR:     rd_mux = {15'h0, op_addr};
		`REG_DATA:     rd_mux = {16'h0, op_data};
		`REG_STATUS:   rd_mux = {14'h0, fail, busy, last_read};
		`REG_IRQ_STAT: rd_mux = {28'h0, irq_stat};
		`REG_IRQ_EN:   rd_mux = {28'h0, irq_en};
		default:       rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			irq       <= 1'b0;
		end else begin
			hrdata    <= rd_mux;
			hreadyout <= ~(hsel & htrans[1] & hready & ~hwrite);
			hresp     <= 1'b0;
			irq       <= |(irq_stat & irq_en);
		end
	end

	// ------------------------------------------------------------
	// pin sync
	// ------------------------------------------------------------
	logic [15:0] din_s1;
	logic [15:0] din_s2;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			din_s1 <= 16'h0000;
			din_s2 <= 16'h0000;
		end else begin
			din_s1 <= flash_din;
			din_s2 <= din_s1;
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	function automatic logic [16:0] cmd_addr(input logic [2:0] op,
			input logic [2:0] idx, input logic [16:0] a);
		if (idx == 3'd1 || idx == 3'd4)
			cmd_addr = {1'b0, `UNLOCK_ADDR2};
		else if (idx == 3'd5 || (op == OP_PROG && idx == 3'd3))
			cmd_addr = a;
		else
			cmd_addr = {1'b0, `UNLOCK_ADDR1};
	endfunction

	function automatic logic [15:0] cmd_data(input logic [2:0] op,
			input logic [2:0] idx, input logic [15:0] d);
		case (idx)
		3'd0, 3'd3: cmd_data = (op == OP_PROG && idx == 3'd3) ? d :
			`UNLOCK_DATA1;
		3'd1, 3'd4: cmd_data = `UNLOCK_DATA2;
		3'd2:       cmd_data = (op == OP_PROG) ? `PROG_CMD : `ERASE_CMD;
		default:    cmd_data = (op == OP_CHIP_ERASE) ? `CHIP_ERASE_CMD :
			`SECT_ERASE_CMD;
		endcase
	endfunction

	state_t      st, next_st;
	logic [2:0]  idx, next_idx, last_idx, next_last_idx;
	logic [35:0] cnt, next_cnt, wdog, next_wdog;
	logic        prev_tog, next_prev_tog, first, next_first;
	logic        next_busy, next_fail;
	logic [15:0] next_last_read;
	logic [3:0]  next_ev;
	flash_pins_t next_pins;
	logic [35:0] limit;

	always_comb begin
		case (ctrl_op)
		// host watchdog bounds
		// program limit
		OP_PROG:       limit = ctrl_word ? 36'(`WORD_PROG_CYC) :
			36'(`BYTE_PROG_CYC);
		OP_CHIP_ERASE: limit = 36'(CHIP_ERASE_CYC);
		default:       limit = 36'(SECT_ERASE_CYC);
		endcase
	end

	always_comb begin
		next_st = st; next_idx = idx; next_last_idx = last_idx;
		next_cnt = cnt; next_wdog = wdog; next_prev_tog = prev_tog;
		next_first = first; next_busy = busy; next_fail = fail;
		next_last_read = last_read; next_ev = 4'h0; next_pins = pins;
		if (st == S_POLL_LOW || st == S_POLL_EVAL)
			next_wdog = wdog + 36'd1;
		case (st)
		S_IDLE: if (start) begin
			next_busy = 1'b1; next_fail = 1'b0; next_idx = 3'd0;
			next_first = 1'b1; next_wdog = 36'd0; next_cnt = 36'd0;
			case (ctrl_op)
			OP_PROG:       begin next_last_idx = 3'd3;
				next_st = S_CMD_SETUP; end
			OP_CHIP_ERASE: begin next_last_idx = 3'd5;
				next_st = S_CMD_SETUP; end
			OP_SECT_ERASE: begin next_last_idx = 3'd5;
				next_st = S_CMD_SETUP; end
			OP_RESET:      begin next_last_idx = 3'd6;
				next_st = S_CMD_SETUP; end
			OP_PROTECT, OP_UNPROTECT: begin
				next_pins.addr = op_addr; next_pins.ce_n = 1'b0;
				next_pins.oe_n = 1'b0; next_st = S_PROT_OE; end
			default: next_busy = 1'b0;
			endcase
		end
		S_CMD_SETUP: begin
			next_pins.addr = (last_idx == 3'd6) ? {1'b0, `UNLOCK_ADDR1} :
				cmd_addr(ctrl_op, idx, op_addr);
			next_pins.dout = (last_idx == 3'd6) ? `RESET_CMD :
				cmd_data(ctrl_op, idx, op_data);
			next_pins.dout_oe_n = 1'b0; next_pins.ce_n = 1'b0;
			next_pins.we_n = 1'b0; next_cnt = 36'd0; next_st = S_CMD_LOW;
		end
		S_CMD_LOW: begin
			next_cnt = cnt + 36'd1;
			if (cnt == 36'(`WE_LOW_CYC - 1)) begin
				next_pins.we_n = 1'b1; next_cnt = 36'd0;
				next_st = S_CMD_HIGH;
			end
		end
		S_CMD_HIGH: begin
			next_cnt = cnt + 36'd1;
			if (cnt == 36'(`CWC_CYC - `WE_LOW_CYC)) begin
				next_pins.dout_oe_n = 1'b1; next_pins.ce_n = 1'b1;
				next_cnt = 36'd0; next_idx = idx + 3'd1;
				if (idx == last_idx || last_idx == 3'd6) begin
					next_st = (last_idx == 3'd6) ? S_IDLE : S_POLL_LOW;
					next_busy = (last_idx != 3'd6);
					if (last_idx == 3'd6) next_ev[0] = 1'b1;
					next_pins.addr = op_addr;
				end else next_st = S_CMD_SETUP;
			end
		end
		S_POLL_LOW: begin
			next_pins.ce_n = 1'b0; next_pins.oe_n = 1'b0;
			next_cnt = cnt + 36'd1;
			if (cnt == 36'(`OE_READ_CYC + 2)) begin
				next_pins.oe_n = 1'b1; next_pins.ce_n = 1'b1;
				next_last_read = din_s2; next_cnt = 36'd0;
				next_st = S_POLL_EVAL;
			end
		end
		S_POLL_EVAL: begin
			next_first = 1'b0; next_prev_tog = last_read[`TOGGLE_BIT];
			next_st = S_POLL_LOW;
			if (!first && last_read[`TOGGLE_BIT] == prev_tog) begin
				next_busy = 1'b0; next_st = S_IDLE;
				if ((ctrl_op == OP_PROG &&
					last_read[`POLL_BIT] != op_data[`POLL_BIT]) ||
					(ctrl_op != OP_PROG && !last_read[`POLL_BIT])) begin
					next_fail = 1'b1; next_ev[1] = 1'b1;
				end else next_ev[0] = 1'b1;
			end else if ((!first && last_read[`LIMIT_BIT]) ||
				wdog >= limit) begin
				next_fail = 1'b1; next_ev[2] = 1'b1;
				next_last_idx = 3'd6; next_st = S_CMD_SETUP;
			end
			// time-out bit is status only while still toggling
			if (last_read[`ETIMEOUT_BIT] && next_st != S_IDLE)
				next_ev[3] = 1'b1;
		end
		S_PROT_OE: begin
			next_cnt = cnt + 36'd1;
			if (cnt == 36'(`OE_SETUP_CYC)) begin
				next_pins.we_n = 1'b0; next_cnt = 36'd0;
				next_st = S_PROT_WE;
			end
		end
		S_PROT_WE: begin
			next_cnt = cnt + 36'd1;
			if (cnt == ((ctrl_op == OP_UNPROTECT) ?
				36'(UNPROT_WE_CYC) : 36'(`PROT_WE_CYC))) begin
				next_pins.we_n = 1'b1; next_st = S_PROT_END;
			end
		end
		S_PROT_END: begin
			next_pins.oe_n = 1'b1; next_pins.ce_n = 1'b1;
			next_busy = 1'b0; next_ev[0] = 1'b1; next_st = S_IDLE;
		end
		default: next_st = S_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st <= S_IDLE; idx <= 3'd0; last_idx <= 3'd0;
			cnt <= 36'd0; wdog <= 36'd0; prev_tog <= 1'b0;
			first <= 1'b1; busy <= 1'b0; fail <= 1'b0;
			last_read <= 16'h0000; ev <= 4'h0;
			pins <= '{addr: 17'h00000, dout: 16'h0000, dout_oe_n: 1'b1,
				ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
		end else begin
			st <= next_st; idx <= next_idx; last_idx <= next_last_idx;
			cnt <= next_cnt; wdog <= next_wdog; prev_tog <= next_prev_tog;
			first <= next_first; busy <= next_busy; fail <= next_fail;
			last_read <= next_last_read; ev <= next_ev; pins <= next_pins;
		end
	end
endmodule // flash_host

// ---- sim/flash_host_assertions.sv ----
/* checker for the flash host pins and bus answer.
   assumes binding onto flash_host; sees only its ports. */
`timescale 1ns/10ps
`include "flash_host_cfg.svh"
module flash_host_assertions
	import flash_host_pkg::*;
#(
	parameter int unsigned UNPROT_WE_CYC = `UNPROT_WE_CYC
) (
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire flash_pins_t pins
);
	// shortened unprotect may fall below the protect minimum
	localparam int unsigned PULSE_MIN =
		(UNPROT_WE_CYC < `PROT_WE_CYC) ? UNPROT_WE_CYC : `PROT_WE_CYC;
	logic [31:0] we_cnt;
	logic [31:0] oe_cnt;
	logic [31:0] next_we_cnt;
	logic [31:0] next_oe_cnt;
	// ----
	// low-time counters
	// ----
	always_comb begin
		next_we_cnt = pins.we_n ? 32'h0 : we_cnt + 32'h1;
		next_oe_cnt = pins.oe_n ? 32'h0 : oe_cnt + 32'h1;
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			we_cnt <= 32'h0;
			oe_cnt <= 32'h0;
		end else begin
			we_cnt <= next_we_cnt;
			oe_cnt <= next_oe_cnt;
		end
	end
	// ----
	// properties
	// ----
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	hresp_okay_a: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	read_wait_a: assert property ($fell(hreadyout) |=> hreadyout)
		else $error("read wait longer than one cycle");
	we_pulse_min_a: assert property (
		$rose(pins.we_n) |-> we_cnt >= `WE_LOW_CYC)
		else $error("write strobe pulse too short");
	protect_pulse_a: assert property (
		$rose(pins.we_n) && !pins.oe_n |-> we_cnt >= PULSE_MIN)
		else $error("protect pulse too short");
	oe_setup_a: assert property (
		$fell(pins.we_n) && !pins.oe_n |-> oe_cnt >= `OE_SETUP_CYC)
		else $error("output strobe setup too short");
	addr_stable_a: assert property (
		!pins.we_n && !$past(pins.we_n) |->
		$stable(pins.addr) && $stable(pins.dout))
		else $error("address or data moved under write strobe");
	ce_select_a: assert property (
		!pins.we_n || !pins.oe_n |-> !pins.ce_n)
		else $error("strobe without chip select");
	no_contention_a: assert property (
		!pins.dout_oe_n |-> pins.oe_n)
		else $error("host drives data during a read");
	unlock_order_a: assert property (
		$fell(pins.we_n) && pins.dout == `UNLOCK_DATA1 &&
		pins.addr[15:0] == `UNLOCK_ADDR1 |-> ##[1:100]
		($fell(pins.we_n) && pins.dout == `UNLOCK_DATA2 &&
		pins.addr[15:0] == `UNLOCK_ADDR2))
		else $error("second unlock write missing");
	cover property ($rose(pins.we_n) && !pins.oe_n);
	cover property ($fell(hreadyout));
	cover property ($fell(pins.we_n) && pins.dout == `PROG_CMD);
endmodule // flash_host_assertions

bind flash_host flash_host_assertions #(.UNPROT_WE_CYC(UNPROT_WE_CYC))
	u_checker (.core_clk(core_clk), .rst(rst), .hreadyout(hreadyout),
	.hresp(hresp), .pins(pins));

// ---- sim/flash_dev_model.sv ----
/* behavioural flash device: command decode, status polling, pulse timing.
   assumes the host pin struct; data lines have no pull-up. */
`timescale 1ns/10ps
module flash_dev_model
	import flash_host_pkg::*;
(
	input  wire flash_pins_t pins,
	output logic [15:0]      flash_din
);
	int          busy_reads = 3, busy = 0, step = 0, writes = 0;
	int          erased_sector = -1;
	logic        fail_mode = 1'b0, bad_data = 1'b0, limit = 1'b0;
	logic        chip_erased = 1'b0, reset_seen = 1'b0;
	logic        erasing = 1'b0, tgl = 1'b0;
	logic [15:0] pdata = 16'h0000, last = 16'h0000;
	realtime     t_oe = 0, t_we = 0, we_ns = 0, oe_ns = 0;
	logic [7:0]  d;
	logic        unl, unl2;
	assign d = pins.dout[7:0];
	assign unl = pins.addr[15:0] == 16'h0555;
	assign unl2 = pins.addr[15:0] == 16'h02AA;
	initial flash_din = 16'h0000;
	// ----
	// command writes
	// ----
	always @(negedge pins.we_n) begin
		t_we = $realtime;
		oe_ns = $realtime - t_oe;
	end
	always @(posedge pins.we_n) begin
		we_ns = $realtime - t_we;
		// a reset edge with the chip deselected is not a write
		if (!pins.ce_n)
			writes++;
		if (pins.oe_n && !pins.ce_n) begin
			if (step == 0 && d == 8'hF0) begin
				reset_seen = 1'b1;
				limit = 1'b0;
				busy = 0;
			end
			case (step)
			0, 4: step = (unl && d == 8'hAA) ? step + 1 : 0;
			1, 5: step = (unl2 && d == 8'h55) ? step + 1 : 0;
			2: step = !unl ? 0 : d == 8'hA0 ? 3 : d == 8'h80 ? 4 : 0;
			default: begin
				if (step == 3)
					pdata = pins.dout;
				else if (d == 8'h10)
					chip_erased = 1'b1;
				else
					erased_sector = int'(pins.addr[15:12]);
				erasing = step == 6;
				busy = busy_reads;
				// last busy word toggles to the final bit 6
				tgl = (erasing || (pdata[6] ^ bad_data)) ^
					busy_reads[0];
				limit = fail_mode;
				step = 0;
			end
			endcase
		end
	end
	// ----
	// status reads
	// ----
	// polling word
	always @(negedge pins.oe_n) begin
		t_oe = $realtime;
		if (pins.we_n && !pins.ce_n) begin
			if (busy > 0 || limit) begin
				tgl = ~tgl;
				if (busy > 0)
					busy--;
				last = {8'h00, erasing ? 1'b0 : ~pdata[7], tgl, limit,
					1'b0, erasing, 3'b000};
			end else
				last = erasing ? 16'hFFFF : (bad_data ? ~pdata : pdata);
			#20 flash_din = last;
		end
	end
	// released lines must not keep looking valid
	always @(posedge pins.oe_n) flash_din = ~last;
endmodule // flash_dev_model

// ---- sim/flash_host_test.sv ----
/* bench for the flash host: bus tasks and operation sequences.
   assumes the checker binds itself and the model drives the data pins. */
`timescale 1ns/10ps
`include "flash_host_cfg.svh"
module flash_host_test import flash_host_pkg::*;;
	localparam int UNPROT = 3000;
	logic        core_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0]  htrans = 2'b00;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
	logic        hreadyout, hresp, irq;
	logic [15:0] flash_din;
	flash_pins_t pins;
	int          miscompares = 0, num_checks = 0, cycles = 0, wbase = 0;

	always #2 core_clk = ~core_clk;
	flash_host #(.SECT_ERASE_CYC(2000), .CHIP_ERASE_CYC(3000),
		.UNPROT_WE_CYC(UNPROT)) DUT (.core_clk(core_clk), .rst(rst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.pins(pins), .flash_din(flash_din), .irq(irq));
	flash_dev_model dev (.pins(pins), .flash_din(flash_din));
	// ----
	// tasks
	// ----
	task tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] dat);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= dat;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task run(input op_t op, input logic [16:0] a, input logic [15:0] dat);
		int n;
		bus(1'b1, `REG_ADDR, {15'h0, a});
		bus(1'b1, `REG_DATA, {16'h0, dat});
		bus(1'b1, `REG_CTRL, {29'h0, op});
		if (op == OP_PROG)
			bus(1'b1, `REG_CTRL, {29'h0, OP_CHIP_ERASE});
		n = 0;
		do begin
			bus(1'b0, `REG_STATUS, 32'h0);
			n++;
		end while (q[16] !== 1'b0 && n < 3000);
		check({31'h0, q[16]}, 32'h0);
		// let done reach the irq flop before callers look at it
		repeat (2) @(posedge core_clk);
	endtask
	task stat(input logic [31:0] mask, input logic [31:0] exp);
		bus(1'b0, `REG_IRQ_STAT, 32'h0);
		check(q & mask, exp);
		bus(1'b1, `REG_IRQ_CLR, 32'hF);
	endtask
	// a hang ends the run with a counted mismatch
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			tally_and_finish;
		end
	end
	// ----
	// sequence
	// ----
	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		check({28'h0, pins.we_n, pins.oe_n, pins.ce_n,
			pins.dout_oe_n}, 32'hF);
		bus(1'b0, 8'h40, 32'h0);
		check(q, 32'h0);
		bus(1'b1, `REG_IRQ_EN, 32'hF);
		dev.busy_reads = 6;
		run(OP_PROG, 17'h01234, 16'h005A);
		check({24'h0, q[7:0]}, 32'h5A);
		check(32'(dev.writes), 32'h4);
		check({31'h0, dev.chip_erased}, 32'h0);
		check({31'h0, irq}, 32'h1);
		stat(32'hF, 32'h1);
		repeat (3) @(posedge core_clk);
		check({31'h0, irq}, 32'h0);
		dev.busy_reads = 3;
		run(OP_SECT_ERASE, 17'h03000, 16'h0000);
		check({31'h0, q[7]}, 32'h1);
		check(32'(dev.erased_sector), 32'h3);
		stat(32'hF, 32'h9);
		run(OP_CHIP_ERASE, 17'h00000, 16'h0000);
		check({31'h0, dev.chip_erased}, 32'h1);
		check({31'h0, q[17]}, 32'h0);
		dev.bad_data = 1'b1;
		run(OP_PROG, 17'h00010, 16'h0080);
		stat(32'h2, 32'h2);
		dev.bad_data = 1'b0;
		dev.fail_mode = 1'b1;
		run(OP_PROG, 17'h00020, 16'h0011);
		check({31'h0, q[17]}, 32'h1);
		check({31'h0, dev.reset_seen}, 32'h1);
		stat(32'h4, 32'h4);
		dev.fail_mode = 1'b0;
		bus(1'b1, `REG_IRQ_EN, 32'h0);
		run(OP_PROTECT, 17'h04000, 16'h0000);
		check(32'(dev.we_ns >= 10000.0), 32'h1);
		check(32'(dev.oe_ns >= 4000.0), 32'h1);
		check({31'h0, irq}, 32'h0);
		stat(32'h1, 32'h1);
		run(OP_UNPROTECT, 17'h04000, 16'h0000);
		check(32'(dev.we_ns >= UNPROT * 4.0), 32'h1);
		wbase = dev.writes;
		run(OP_RESET, 17'h00000, 16'h0000);
		check(32'(dev.writes - wbase), 32'h1);
		tally_and_finish;
	end
endmodule // flash_host_test
